// file: hdl/nvs_defines.vh
// Purpose: Constants for the serial nonvolatile SRAM slave.
// Assumes: 50 MHz system clock.
// Notes: Times are in their own units; cycle counts derive from them.
`ifndef NVS_DEFINES_VH
`define NVS_DEFINES_VH
`define NVS_CLK_MHZ 50
`define NVS_OPCODE 4'hA
`define NVS_FIXED_BIT 1'b1
`define NVS_RESTORE_US 550
`define NVS_SAVE_MS 10
`define NVS_RESTORE_CYC (`NVS_RESTORE_US * `NVS_CLK_MHZ)
`define NVS_SAVE_CYC (`NVS_SAVE_MS * 1000 * `NVS_CLK_MHZ)
`define NVS_ADDR_W 13
`define NVS_PROT_TOP 2'h3
`define NVS_DEPTH 8192
`endif

// file: hdl/nvs_slave.v
// Purpose: Two-wire slave front end with save/restore sequencing for a backed-up SRAM.
// Assumes: Serial clock, data, chip-select, protect and capacitor level are asynchronous.
// Notes: The capacitor comparator output arrives as a level, high when above the trip.
`timescale 1ns/1ps
`include "nvs_defines.vh"
// Contract
// - Respond only when chip-select bits match pins.
// - Data line driven low or released only.
// - Data change with clock high is start/stop.
// - Protect input discards upper-quarter writes, still acknowledges.
// - Protect input never affects reads.
// - Save only when array modified since last.
// - Falling capacitor starts save, blocks save+restore.
// - Supply return during save: finish, then restore.
// - Every capacitor rise starts a restore.
// - Power loss aborts restore, no save.
// - No control-byte acknowledge while busy.
// - Below trip: inaccessible, no acknowledge.
// - Disconnect supply; reconnect after save and supply high.
// - Falling data with clock high is start.
// - Rising data with clock high is stop.
// - Bus idle when both lines high.
// - One bit per clock pulse, sampled clock high.
// - Receiver holds data low in acknowledge slot.
// - Master not-acknowledge ends read, line released.
// - Mismatched control byte gets no acknowledges.
// - Control byte: opcode, chip-selects, fixed one, direction.
// - Direction bit one reads, zero writes.
// - Restore finishes within 550 microseconds.
module nvs_slave #(
  parameter SAVE_CYC = `NVS_SAVE_CYC,
  parameter RESTORE_CYC = `NVS_RESTORE_CYC
) (
  input wire clk_i,
  input wire nrst_i,
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  input wire chip_select_pin_low_i,
  input wire chip_select_pin_high_i,
  input wire write_protect_i,
  input wire backup_capacitor_pin_above_trip_i,
  input wire supply_above_cap_i,
  output reg supply_connected_o,
  output reg busy_o,
  output reg saving_o,
  output reg restoring_o
);
  // ==========================================================
  // Input synchronisers
  reg [1:0] scl_s;
  reg [1:0] sda_s;
  reg [1:0] csl_s;
  reg [1:0] csh_s;
  reg [1:0] wp_s;
  reg [1:0] cap_s;
  reg [1:0] sup_s;
  reg scl_d;
  reg sda_d;
  reg cap_d;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      csl_s <= 2'h0;
      csh_s <= 2'h0;
      wp_s <= 2'h0;
      cap_s <= 2'h0;
      sup_s <= 2'h0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      cap_d <= 1'b0;
    end else begin
      scl_s <= {scl_s[0], scl_i};
      sda_s <= {sda_s[0], sda_i};
      csl_s <= {csl_s[0], chip_select_pin_low_i};
      csh_s <= {csh_s[0], chip_select_pin_high_i};
      wp_s <= {wp_s[0], write_protect_i};
      cap_s <= {cap_s[0], backup_capacitor_pin_above_trip_i};
      sup_s <= {sup_s[0], supply_above_cap_i};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
      cap_d <= cap_s[1];
    end
  end
  wire scl = scl_s[1];
  wire sda = sda_s[1];
  wire cap_hi = cap_s[1];
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_det = scl & scl_d & sda_d & ~sda;
  wire stop_det = scl & scl_d & ~sda_d & sda;
  wire cap_fall = cap_d & ~cap_hi;
  wire cap_rise = ~cap_d & cap_hi;

  // ==========================================================
  // Save and restore sequencer
  localparam PS_IDLE = 2'h0;
  localparam PS_SAVE = 2'h1;
  localparam PS_REST = 2'h2;
  localparam PS_OFF = 2'h3;
  reg [1:0] pstate;
  reg [31:0] pcount;
  reg modified;
  reg wr_commit;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pstate <= PS_OFF;
      pcount <= 32'h0;
      modified <= 1'b0;
      supply_connected_o <= 1'b0;
    end else begin
      if (!supply_connected_o && sup_s[1] && pstate != PS_SAVE) begin
        supply_connected_o <= 1'b1;
      end
      case (pstate)
        PS_IDLE: begin
          if (cap_fall) begin
            supply_connected_o <= 1'b0;
            if (modified) begin
              pstate <= PS_SAVE;
              pcount <= SAVE_CYC;
            end else begin
              pstate <= PS_OFF;
            end
          end
        end
        PS_SAVE: begin
          if (pcount <= 32'h1) begin
            modified <= 1'b0;
            // With the capacitor still low, wait powered down for its rise instead.
            pstate <= cap_hi ? PS_REST : PS_OFF;
            pcount <= RESTORE_CYC;
          end else begin
            pcount <= pcount - 32'h1;
          end
        end
        PS_REST: begin
          if (cap_fall) begin
            supply_connected_o <= 1'b0;
            pstate <= PS_OFF;
          end else if (!cap_hi) begin
            pcount <= RESTORE_CYC;
          end else if (pcount <= 32'h1) begin
            modified <= 1'b0;
            pstate <= PS_IDLE;
          end else begin
            pcount <= pcount - 32'h1;
          end
        end
        PS_OFF: begin
          if (cap_rise || cap_hi) begin
            pstate <= PS_REST;
            pcount <= RESTORE_CYC;
          end
        end
        default: begin
          pstate <= PS_OFF;
        end
      endcase
      // A write landing as a save or restore completes must survive, so set wins.
      if (wr_commit) begin
        modified <= 1'b1;
      end
    end
  end
  // Busy also covers the powered-down state, so nothing is acknowledged below the trip.
  wire busy = (pstate != PS_IDLE) | ~cap_hi;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_o <= 1'b1;
      saving_o <= 1'b0;
      restoring_o <= 1'b0;
    end else begin
      busy_o <= busy;
      saving_o <= (pstate == PS_SAVE);
      restoring_o <= (pstate == PS_REST);
    end
  end

  // ==========================================================
  // Serial protocol engine
  localparam BS_IDLE = 3'h0;
  localparam BS_CTRL = 3'h1;
  localparam BS_AHI = 3'h2;
  localparam BS_ALO = 3'h3;
  localparam BS_WDAT = 3'h4;
  localparam BS_RDAT = 3'h5;
  reg [2:0] bstate;
  reg [3:0] bitcnt;
  reg [7:0] shreg;
  reg [7:0] txreg;
  reg ack_slot;
  reg ack_drive;
  reg tx_drive;
  reg mack;
  // Marks a data byte's acknowledge slot, so an address byte never lands in the array.
  reg wr_slot;
  reg cs_ok_q;
  reg [`NVS_ADDR_W-1:0] ptr;
  reg [7:0] mem [0:`NVS_DEPTH-1];
  reg [7:0] rd_data;
  wire [7:0] byte_in = {shreg[6:0], sda};
  wire cs_ok = (byte_in[7:4] == `NVS_OPCODE) & (byte_in[1] == `NVS_FIXED_BIT)
    & (byte_in[3] == csh_s[1]) & (byte_in[2] == csl_s[1]);
  wire prot_hit = wp_s[1] & (ptr[`NVS_ADDR_W-1:`NVS_ADDR_W-2] == `NVS_PROT_TOP);
  always @(posedge clk_i) begin
    if (wr_commit) begin
      mem[ptr] <= shreg;
    end
    rd_data <= mem[ptr];
  end
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bstate <= BS_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      txreg <= 8'hFF;
      ack_slot <= 1'b0;
      ack_drive <= 1'b0;
      tx_drive <= 1'b0;
      mack <= 1'b0;
      ptr <= {`NVS_ADDR_W{1'b0}};
      wr_commit <= 1'b0;
      wr_slot <= 1'b0;
    end else begin
      wr_commit <= 1'b0;
      if (start_det) begin
        bstate <= BS_CTRL;
        bitcnt <= 4'h0;
        ack_slot <= 1'b0;
        ack_drive <= 1'b0;
        tx_drive <= 1'b0;
        wr_slot <= 1'b0;
      end else if (stop_det || busy) begin
        // Save, restore or a low capacitor ends any transfer, so nothing slips past busy.
        bstate <= BS_IDLE;
        ack_drive <= 1'b0;
        tx_drive <= 1'b0;
        ack_slot <= 1'b0;
        wr_slot <= 1'b0;
      end else if (bstate != BS_IDLE) begin
        if (scl_rise) begin
          if (ack_slot) begin
            mack <= ~sda;
            if (wr_slot && !prot_hit) begin
              wr_commit <= 1'b1;
            end
          end else begin
            shreg <= byte_in;
            bitcnt <= bitcnt + 4'h1;
          end
        end
        if (scl_fall) begin
          if (ack_slot) begin
            ack_slot <= 1'b0;
            ack_drive <= 1'b0;
            bitcnt <= 4'h0;
            wr_slot <= 1'b0;
            if (wr_slot) begin
              ptr <= ptr + 1'b1;
            end
            if (bstate == BS_RDAT) begin
              if (tx_drive || mack) begin
                txreg <= rd_data;
                tx_drive <= 1'b1;
              end else begin
                tx_drive <= 1'b0;
                bstate <= BS_IDLE;
              end
            end
          end else if (bitcnt == 4'h8) begin
            ack_slot <= 1'b1;
            tx_drive <= 1'b0;
            case (bstate)
              BS_CTRL: begin
                if (cs_ok_q && !busy) begin
                  ack_drive <= 1'b1;
                  bstate <= shreg[0] ? BS_RDAT : BS_AHI;
                  mack <= 1'b1;
                end else begin
                  bstate <= BS_IDLE;
                end
              end
              BS_AHI: begin
                ptr[`NVS_ADDR_W-1:8] <= shreg[`NVS_ADDR_W-9:0];
                ack_drive <= 1'b1;
                bstate <= BS_ALO;
              end
              BS_ALO: begin
                ptr[7:0] <= shreg;
                ack_drive <= 1'b1;
                bstate <= BS_WDAT;
              end
              BS_WDAT: begin
                ack_drive <= 1'b1;
                wr_slot <= 1'b1;
              end
              BS_RDAT: begin
                if (tx_drive) begin
                  ptr <= ptr + 1'b1;
                end
              end
              default: begin
                bstate <= BS_IDLE;
              end
            endcase
          end else if (bstate == BS_RDAT && tx_drive) begin
            txreg <= {txreg[6:0], 1'b1};
          end
        end
      end
    end
  end
  // Control byte match is latched with the eighth bit so the ack slot sees a stable answer.
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cs_ok_q <= 1'b0;
    end else if (scl_rise && !ack_slot && bitcnt == 4'h7) begin
      cs_ok_q <= cs_ok;
    end
  end
  wire drive_low = ack_drive | (tx_drive & ~txreg[7]);
  assign sda_o = 1'b0;
  assign sda_oe_o = drive_low;
endmodule

// file: testbench/nvs_master_model.sv
// Purpose: Bus master model for the slave's two-wire pins.
// Assumes: Phases counted in clock cycles at the falling edge.
// Notes: Open drain; the bench resolves the wire with a pull-up.
`timescale 1ns/1ps
module nvs_master_model (
  input wire clk_i,
  input wire sda_i,
  output reg scl_o,
  output reg sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // Start is a=0 b=1, stop is a=1 b=0.
  task cond(input a, input b);
    begin
      @(negedge clk_i);
      sda_low_o = a;
      repeat (3) @(negedge clk_i);
      scl_o = 1'b1;
      repeat (4) @(negedge clk_i);
      sda_low_o = b;
      repeat (4) @(negedge clk_i);
      scl_o = ~b;
    end
  endtask
  // Data moves a cycle after the clock falls, so both synchronisers agree on order.
  task xbit(input b, output s);
    begin
      @(negedge clk_i);
      sda_low_o = ~b;
      repeat (3) @(negedge clk_i);
      scl_o = 1'b1;
      repeat (2) @(negedge clk_i);
      s = sda_i;
      repeat (2) @(negedge clk_i);
      scl_o = 1'b0;
    end
  endtask
  task xbyte(input [7:0] b, input last, output [7:0] d, output ack);
    integer i;
    reg s;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        xbit(b[i], s);
        d[i] = s;
      end
      xbit(last, s);
      ack = ~s;
    end
  endtask
endmodule

// file: testbench/nvs_slave_monitor.sv
// Purpose: Port assertions for the backed-up SRAM slave.
// Assumes: One clock domain, async active-low reset.
// Notes: Restore bound follows RESTORE_CYC.
`timescale 1ns/1ps
module nvs_slave_monitor #(parameter RESTORE_CYC = 30) (
  input wire clk_i,
  input wire nrst_i,
  input wire sda_o,
  input wire sda_oe_o,
  input wire backup_capacitor_pin_above_trip_i,
  input wire supply_connected_o,
  input wire busy_o,
  input wire saving_o,
  input wire restoring_o
);
  wire cap = backup_capacitor_pin_above_trip_i;
  reg [19:0] rcnt;
  // A counter keeps a long restore bound cheap to check.
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i)
      rcnt <= 20'h00000;
    else
      rcnt <= restoring_o ? rcnt + 20'h00001 : 20'h00000;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_low; !cap [*6]; endsequence
  sequence s_abort; (restoring_o && !cap) [*2]; endsequence
  property p_od; sda_oe_o |-> !sda_o; endproperty
  a_od: assert property (p_od) else $error("line driven high");
  property p_low; s_low |-> busy_o; endproperty
  a_low: assert property (p_low) else $error("open below trip");
  property p_busy; busy_o [*8] |-> !sda_oe_o; endproperty
  a_busy: assert property (p_busy) else $error("ack while busy");
  property p_save; saving_o |-> busy_o && !supply_connected_o; endproperty
  a_save: assert property (p_save) else $error("save not isolated");
  property p_rise; $rose(cap) && !saving_o |-> ##[1:6] restoring_o; endproperty
  a_rise: assert property (p_rise) else $error("no restore");
  property p_abort; s_abort |-> ##[0:6] !restoring_o ##1 !saving_o [*8]; endproperty
  a_abort: assert property (p_abort) else $error("restore not aborted");
  property p_chain; $fell(saving_o) && cap |-> ##[0:3] restoring_o; endproperty
  a_chain: assert property (p_chain) else $error("no restore after save");
  property p_rdur; rcnt <= RESTORE_CYC + 2; endproperty
  a_rdur: assert property (p_rdur) else $error("restore too long");
endmodule
bind nvs_slave nvs_slave_monitor #(.RESTORE_CYC(RESTORE_CYC)) i_nvs_slave_monitor (
  .clk_i(clk_i), .nrst_i(nrst_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .backup_capacitor_pin_above_trip_i(backup_capacitor_pin_above_trip_i),
  .supply_connected_o(supply_connected_o), .busy_o(busy_o), .saving_o(saving_o),
  .restoring_o(restoring_o));

// file: testbench/nvs_slave_tb.sv
// Purpose: Self-checking bench for the backed-up SRAM slave.
// Assumes: 20 ns clock, 160 ns bus bit.
// Notes: Save and restore shortened by parameter.
`timescale 1ns/1ps
module nvs_slave_tb;
  localparam RC = 300;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg cap = 1'b1;
  reg sup = 1'b1;
  reg wp = 1'b0;
  reg [1:0] cs = 2'b10;
  reg a;
  reg [7:0] d;
  integer n_mismatch = 0;
  integer comparisons = 0;
  integer i;
  integer j;
  wire scl, low, oe, sdo, busy, sav, rst, con;
  wire sda = ~low & (oe ? sdo : 1'b1);
  nvs_slave #(.SAVE_CYC(400), .RESTORE_CYC(RC)) i_nvs_slave (
    .clk_i(clk), .nrst_i(nrst), .scl_i(scl), .sda_i(sda), .sda_o(sdo), .sda_oe_o(oe),
    .chip_select_pin_low_i(cs[0]), .chip_select_pin_high_i(cs[1]), .write_protect_i(wp),
    .backup_capacitor_pin_above_trip_i(cap), .supply_above_cap_i(sup),
    .supply_connected_o(con), .busy_o(busy), .saving_o(sav), .restoring_o(rst));
  nvs_master_model i_nvs_master_model (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(low));
  initial forever #10 clk = ~clk;
  function [7:0] cb(input [1:0] c, input r);
    cb = {4'hA, c, 1'b1, r};
  endfunction
  task chk(input [15:0] g, input [15:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task end_sim;
    begin
      if (n_mismatch == 0 && comparisons > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task bt(input [7:0] b, input l);
    i_nvs_master_model.xbyte(b, l, d, a);
  endtask
  task adr(input [12:0] ad);
    begin
      i_nvs_master_model.cond(1'b0, 1'b1);
      bt(cb(cs, 1'b0), 1'b1);
      chk(a, 1'b1);
      bt({3'h0, ad[12:8]}, 1'b1);
      chk(a, 1'b1);
      bt(ad[7:0], 1'b1);
      chk(a, 1'b1);
    end
  endtask
  task wr(input [12:0] ad, input [7:0] v);
    begin
      adr(ad);
      bt(v, 1'b1);
      chk(a, 1'b1);
      i_nvs_master_model.cond(1'b1, 1'b0);
    end
  endtask
  task rd(input [12:0] ad, input [7:0] e);
    begin
      adr(ad);
      i_nvs_master_model.cond(1'b0, 1'b1);
      bt(cb(cs, 1'b1), 1'b1);
      chk(a, 1'b1);
      bt(8'hFF, 1'b1);
      chk(d, e);
      i_nvs_master_model.cond(1'b1, 1'b0);
    end
  endtask
  task ctl(input [7:0] b);
    begin
      i_nvs_master_model.cond(1'b0, 1'b1);
      bt(b, 1'b1);
    end
  endtask
  task poll;
    begin
      a = 1'b0;
      for (j = 0; j < 40 && a !== 1'b1; j = j + 1)
        ctl(cb(cs, 1'b0));
      i_nvs_master_model.cond(1'b1, 1'b0);
      chk(a, 1'b1);
    end
  endtask
  task sc_boot;
    begin
      chk(busy, 1'b1);
      for (i = 0; i < RC + 40 && busy !== 1'b0; i = i + 1)
        @(negedge clk);
      chk({busy, con}, 2'b01);
    end
  endtask
  task sc_addr;
    integer c;
    integer b;
    begin
      for (c = 0; c < 4; c = c + 1) begin
        cs = c[1:0];
        for (b = 0; b < 4; b = b + 1) begin
          ctl(cb(b[1:0], 1'b0));
          chk(a, b == c);
          bt(8'h00, 1'b1);
          chk(a, b == c);
          i_nvs_master_model.cond(1'b1, 1'b0);
        end
      end
      cs = 2'b10;
      ctl({4'h5, cs, 2'b10});
      chk(a, 1'b0);
      ctl({4'hA, cs, 2'b00});
      chk(a, 1'b0);
      i_nvs_master_model.cond(1'b1, 1'b0);
    end
  endtask
  task sc_wp;
    begin
      wr(13'h1800, 8'h3C);
      wp = 1'b1;
      wr(13'h1800, 8'hC3);
      wr(13'h17FF, 8'h22);
      rd(13'h1800, 8'h3C);
      rd(13'h17FF, 8'h22);
      adr(13'h17FF);
      i_nvs_master_model.cond(1'b0, 1'b1);
      bt(cb(cs, 1'b1), 1'b1);
      chk(a, 1'b1);
      bt(8'hFF, 1'b0);
      chk(d, 8'h22);
      bt(8'hFF, 1'b1);
      chk(d, 8'h3C);
      chk(a, 1'b0);
      i_nvs_master_model.cond(1'b1, 1'b0);
      wp = 1'b0;
    end
  endtask
  task sc_save;
    begin
      cap = 1'b0;
      sup = 1'b0;
      repeat (10) @(negedge clk);
      chk({sav, con}, 2'b10);
      ctl(cb(cs, 1'b0));
      chk(a, 1'b0);
      cap = 1'b1;
      sup = 1'b1;
      repeat (5) @(negedge clk);
      chk(con, 1'b0);
      poll;
      chk(j > 5, 1'b1);
      chk(con, 1'b1);
    end
  endtask
  task sc_nosave;
    begin
      sup = 1'b0;
      cap = 1'b0;
      repeat (20) @(negedge clk);
      chk({sav, busy}, 2'b01);
      cap = 1'b1;
      sup = 1'b1;
      repeat (10) @(negedge clk);
      chk(rst, 1'b1);
      cap = 1'b0;
      repeat (20) @(negedge clk);
      chk({rst, sav}, 2'b00);
      cap = 1'b1;
      poll;
    end
  endtask
  initial begin
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    sc_boot;
    sc_addr;
    sc_wp;
    sc_save;
    sc_nosave;
    end_sim;
  end
  initial begin
    #1200000;
    n_mismatch = n_mismatch + 1;
    end_sim;
  end
endmodule
